// [rtl/wdg_watchdog.sv]
`timescale 1ns/1ns
`default_nettype none
module wdg_watchdog
    import wdg_pkg::*;
#(
    parameter int unsigned CNT_W                  = 32,
    parameter int unsigned CAP_W                  = 11,
    parameter int unsigned DEFAULT_TIMEOUT_CYC    = DEFAULT_TIMEOUT_CYCLES,
    parameter int unsigned PULLUP_TIMEOUT_CYC     = PULLUP_TIMEOUT_CYCLES,
    parameter int unsigned CAP_SLOPE_CYC          = CAP_SLOPE_CYCLES,
    parameter int unsigned CAP_OFFSET_CYC         = CAP_OFFSET_CYCLES
) (
    input  wire logic             core_clk,
    input  wire logic             rst_n,
    input  wire logic             kick_input,
    input  wire logic             supervision_select,
    input  wire logic             enable_input,
    input  wire logic             timeout_program_pin,
    input  wire logic [CAP_W-1:0] timing_capacitor_nf,
    output logic                  fault_output_n,
    output logic                  fault_output_n_oe,
    output logic                  enable_mirror_output
);
    if (CNT_W < 24 || CNT_W > 32 || CAP_W < 1 || CAP_W > 16) begin : g_bad_width
        $error("wdg_watchdog: unsupported counter or capacitor width");
    end

    logic             rst_meta;
    logic             rst_sync;
    wdg_state_t       state;
    wdg_state_t       next_state;
    wdg_mode_t        mode;
    logic [SEQ_W-1:0] seq_cnt;
    logic [CNT_W-1:0] limit;
    logic             kick_prev;
    logic [CNT_W-1:0] elapsed;
    logic             expired;

    // reset released through two flops
    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_meta <= 1'b0;
            rst_sync <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_sync <= rst_meta;
        end
    end

    wire              active     = enable_input && supervision_select;
    wire              kick_fall  = kick_prev && !kick_input;
    wire              in_run     = (state == ST_RUN);
    wire              kick_valid = in_run && active && kick_fall;
    wire              seq_done_e = (seq_cnt == SEQ_W'(INIT_CYCLES - 1));
    wire              seq_done_s = (seq_cnt == SEQ_W'(SETUP_CYCLES - 1));
    wire [CNT_W-1:0]  cap_limit  = CNT_W'(timing_capacitor_nf) * CNT_W'(CAP_SLOPE_CYC)
                                   + CNT_W'(CAP_OFFSET_CYC);
    wire wdg_mode_t   eval_mode  = timeout_program_pin ? MODE_PULLUP :
                                   (timing_capacitor_nf != '0) ? MODE_CAP : MODE_OPEN;
    wire [CNT_W-1:0]  eval_limit = (eval_mode == MODE_CAP)    ? cap_limit :
                                   (eval_mode == MODE_PULLUP) ? CNT_W'(PULLUP_TIMEOUT_CYC) :
                                   CNT_W'(DEFAULT_TIMEOUT_CYC);
    wire              next_fault = in_run && active && expired && !kick_fall;

    always_comb begin
        next_state = state;
        case (state)
            ST_EVAL: begin
                if (seq_done_e) begin
                    next_state = active ? ST_SETUP : ST_OFF;
                end
            end
            ST_SETUP: begin
                if (!active) begin
                    next_state = ST_OFF;
                end else if (seq_done_s) begin
                    next_state = ST_RUN;
                end
            end
            ST_RUN: begin
                if (!active) begin
                    next_state = ST_OFF;
                end
            end
            ST_OFF: begin
                if (active) begin
                    next_state = ST_SETUP;
                end
            end
            default: begin
                next_state = ST_EVAL;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            state <= ST_EVAL;
        end else begin
            state <= next_state;
        end
    end

    // shared sequencer for evaluation and setup intervals
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            seq_cnt <= '0;
        end else if (next_state != state) begin
            seq_cnt <= '0;
        end else if (state == ST_EVAL || state == ST_SETUP) begin
            seq_cnt <= seq_cnt + 1'b1;
        end
    end

    // timing pin configuration caught once at end of evaluation
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            mode  <= MODE_OPEN;
            limit <= CNT_W'(DEFAULT_TIMEOUT_CYC);
        end else if (state == ST_EVAL && seq_done_e) begin
            mode  <= eval_mode;
            limit <= eval_limit;
        end
    end

    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            kick_prev <= 1'b0;
        end else begin
            kick_prev <= kick_input;
        end
    end

    wdg_interval_counter #(
        .CNT_W (CNT_W)
    ) u_interval (
        .clk     (core_clk),
        .rst_n   (rst_sync),
        .clear   (!in_run || !active || kick_fall),
        .run     (in_run && active),
        .limit   (limit),
        .elapsed (elapsed),
        .expired (expired)
    );

    // open-drain fault pin: level is always low, enable pulls it
    always_ff @(posedge core_clk or negedge rst_sync) begin
        if (!rst_sync) begin
            fault_output_n       <= 1'b0;
            fault_output_n_oe    <= 1'b0;
            enable_mirror_output <= 1'b0;
        end else begin
            fault_output_n       <= 1'b0;
            fault_output_n_oe    <= next_fault;
            enable_mirror_output <= enable_input;
        end
    end

    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_sync);

    property p_mirror_low;
        !enable_input |=> !enable_mirror_output;
    endproperty
    a_mirror_low: assert property (p_mirror_low) else $error("mirror not low");

    property p_disable_release;
        !supervision_select || !enable_input |=> !fault_output_n_oe ##1 !fault_output_n_oe;
    endproperty
    a_disable_release: assert property (p_disable_release) else $error("fault while off");

    property p_kick_recovers;
        kick_valid |=> !fault_output_n_oe && elapsed == '0;
    endproperty
    a_kick_recovers: assert property (p_kick_recovers) else $error("kick not honoured");

    property p_rise_no_restart;
        in_run && active && !kick_prev && kick_input && !expired |=> elapsed == $past(elapsed) + 1;
    endproperty
    a_rise_no_restart: assert property (p_rise_no_restart) else $error("rise restarted");

    property p_eval_end;
        state == ST_EVAL && seq_done_e |=> state != ST_EVAL && limit == $past(eval_limit);
    endproperty
    a_eval_end: assert property (p_eval_end) else $error("evaluation end wrong");

    property p_eval_hold;
        state == ST_EVAL && !seq_done_e |=> state == ST_EVAL;
    endproperty
    a_eval_hold: assert property (p_eval_hold) else $error("evaluation too short");

    property p_setup_quiet;
        state == ST_OFF && active ##1 (active)[*8] |=> state == ST_SETUP;
    endproperty
    a_setup_quiet: assert property (p_setup_quiet) else $error("setup skipped");

    property p_timeout_fault;
        in_run && active && expired && !kick_fall |=> fault_output_n_oe;
    endproperty
    a_timeout_fault: assert property (p_timeout_fault) else $error("missed timeout");

    property p_no_early_fault;
        $rose(fault_output_n_oe) |-> $past(elapsed) >= limit;
    endproperty
    a_no_early_fault: assert property (p_no_early_fault) else $error("early fault");

    property p_cap_limit;
        state != ST_EVAL && mode == MODE_CAP |-> limit != '0 && limit >= CNT_W'(CAP_OFFSET_CYC);
    endproperty
    a_cap_limit: assert property (p_cap_limit) else $error("bad capacitor limit");

    property p_open_default;
        state != ST_EVAL && mode == MODE_OPEN |-> limit == CNT_W'(DEFAULT_TIMEOUT_CYC);
    endproperty
    a_open_default: assert property (p_open_default) else $error("bad default limit");

    c_fault: cover property ($rose(fault_output_n_oe));
    c_recover: cover property (fault_output_n_oe ##1 !fault_output_n_oe && in_run);
    c_reenable: cover property (state == ST_SETUP ##1 state == ST_RUN);
    c_cap_run: cover property (mode == MODE_CAP && in_run);
endmodule // wdg_watchdog
`default_nettype wire

// [rtl/wdg_pkg.sv]
package wdg_pkg;
    localparam int unsigned CLK_HZ             = 10_000_000;
    localparam int unsigned CYCLES_PER_MS      = CLK_HZ / 1000;
    localparam int unsigned INIT_US            = 381;
    localparam int unsigned SETUP_US           = 150;
    localparam int unsigned DEFAULT_TIMEOUT_MS = 1600;
    localparam int unsigned PULLUP_TIMEOUT_MS  = 200;
    localparam int unsigned CAP_SLOPE_TENTH_MS = 774;
    localparam int unsigned CAP_OFFSET_MS      = 55;
    // least times, rounded up to whole cycles
    localparam int unsigned INIT_CYCLES  = (INIT_US * CYCLES_PER_MS + 999) / 1000;
    localparam int unsigned SETUP_CYCLES = (SETUP_US * CYCLES_PER_MS + 999) / 1000;
    localparam int unsigned DEFAULT_TIMEOUT_CYCLES = DEFAULT_TIMEOUT_MS * CYCLES_PER_MS;
    localparam int unsigned PULLUP_TIMEOUT_CYCLES  = PULLUP_TIMEOUT_MS * CYCLES_PER_MS;
    localparam int unsigned CAP_SLOPE_CYCLES       = CAP_SLOPE_TENTH_MS * CYCLES_PER_MS / 10;
    localparam int unsigned CAP_OFFSET_CYCLES      = CAP_OFFSET_MS * CYCLES_PER_MS;
    localparam int unsigned SEQ_W = 12;

    typedef enum logic [1:0] {
        ST_EVAL  = 2'b00,
        ST_SETUP = 2'b01,
        ST_RUN   = 2'b10,
        ST_OFF   = 2'b11
    } wdg_state_t;

    typedef enum logic [1:0] {
        MODE_OPEN   = 2'b00,
        MODE_PULLUP = 2'b01,
        MODE_CAP    = 2'b10
    } wdg_mode_t;
endpackage

// [rtl/wdg_interval_counter.sv]
`timescale 1ns/1ns
`default_nettype none
module wdg_interval_counter #(
    parameter int CNT_W = 32
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             run,
    input  wire logic [CNT_W-1:0] limit,
    output logic      [CNT_W-1:0] elapsed,
    output logic                  expired
);
    logic [CNT_W-1:0] count;
    wire              at_limit = (count >= limit);

    // saturates at the limit so the fault holds until a clear
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count <= '0;
        end else if (clear) begin
            count <= '0;
        end else if (run && !at_limit) begin
            count <= count + 1'b1;
        end
    end

    assign elapsed = count;
    assign expired = at_limit;
endmodule // wdg_interval_counter
`default_nettype wire

// [testbench/wdg_host_model.sv]
`timescale 1ns/1ns
`default_nettype none
module wdg_host_model (
    input  wire logic core_clk,
    output logic      kick_input,
    output logic      supervision_select,
    output logic      enable_input
);
    initial begin
        kick_input = 1'b1;
        supervision_select = 1'b1;
        enable_input = 1'b1;
    end
    task automatic set_kick(input logic v);
        @(posedge core_clk);
        kick_input <= v;
    endtask
    // one falling edge, spaced by the caller below the least timeout
    task automatic kick();
        set_kick(1'b1);
        set_kick(1'b0);
    endtask
    // gpio style select, may change at any time
    task automatic set_select(input logic v);
        @(posedge core_clk);
        supervision_select <= v;
    endtask
    task automatic set_enable(input logic v);
        @(posedge core_clk);
        enable_input <= v;
    endtask
endmodule // wdg_host_model
`default_nettype wire

// [testbench/programmable_watchdog_timer_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module programmable_watchdog_timer_tb;
    import wdg_pkg::*;
    localparam int unsigned SLOPE = 10;
    localparam int unsigned OFFS  = 20;
    logic        core_clk;
    logic        rst_n;
    logic        timeout_program_pin;
    logic [10:0] timing_capacitor_nf;
    wire logic   kick_input;
    wire logic   supervision_select;
    wire logic   enable_input;
    wire logic   fault_output_n;
    wire logic   fault_output_n_oe;
    wire logic   enable_mirror_output;
    // open drain pin with pull-up
    wire logic   fault_pin = fault_output_n_oe ? fault_output_n : 1'b1;
    int          lim;
    int          error_cnt = 0;
    int          cmp_count = 0;
    initial core_clk = 1'b0;
    always #50 core_clk = ~core_clk;
    wdg_host_model host (.core_clk(core_clk), .kick_input(kick_input),
        .supervision_select(supervision_select), .enable_input(enable_input));
    wdg_watchdog #(.DEFAULT_TIMEOUT_CYC(200), .PULLUP_TIMEOUT_CYC(50),
        .CAP_SLOPE_CYC(SLOPE), .CAP_OFFSET_CYC(OFFS)) dut (
        .core_clk(core_clk), .rst_n(rst_n), .kick_input(kick_input),
        .supervision_select(supervision_select), .enable_input(enable_input),
        .timeout_program_pin(timeout_program_pin), .timing_capacitor_nf(timing_capacitor_nf),
        .fault_output_n(fault_output_n), .fault_output_n_oe(fault_output_n_oe),
        .enable_mirror_output(enable_mirror_output));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
        if (error_cnt == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #1;
    endtask
    // bounded wait for the pin to drop, must fall inside lo..hi cycles
    task automatic expect_fault(input string what, input int lo, input int hi);
        int n;
        n = 0;
        // look off the edge so the pin has settled
        #1;
        while (fault_pin !== 1'b0 && n <= hi) begin
            step(1);
            n++;
        end
        check(what, (n >= lo && n <= hi), 1'b1);
        if (n > hi) tally_and_finish();
    endtask
    task automatic hold_quiet(input string what, input int n);
        int lows;
        lows = 0;
        repeat (n) begin
            step(1);
            lows += (fault_pin !== 1'b1);
        end
        check(what, lows, 0);
    endtask
    task automatic run_mode(input logic pu, input logic [10:0] cap, input int l);
        lim = l;
        @(posedge core_clk);
        rst_n <= 1'b0;
        timeout_program_pin <= pu;
        timing_capacitor_nf <= cap;
        repeat (12) @(posedge core_clk);
        rst_n <= 1'b1;
        step(3000);
        check("mirror_eval", enable_mirror_output, 1'b1);
        check("pin_eval", fault_pin, 1'b1);
        host.kick();
        expect_fault("first_timeout", 2310 + lim - 6, 2310 + lim + 8);
        host.set_kick(1'b1);
        step(5);
        check("pin_after_rise", fault_pin, 1'b0);
        host.set_kick(1'b0);
        step(3);
        check("pin_after_fall", fault_pin, 1'b1);
        repeat (4) begin
            host.kick();
            hold_quiet("kick_train", lim * 3 / 4);
        end
        host.kick();
        expect_fault("timeout", lim - 3, lim + 6);
    endtask
    task automatic select_scenario();
        host.set_select(1'b0);
        step(2);
        check("pin_select_low", fault_pin, 1'b1);
        hold_quiet("select_low", lim + 20);
        host.set_select(1'b1);
        step(700);
        host.kick();
        expect_fault("after_setup", 800 + lim - 8, 800 + lim + 8);
    endtask
    task automatic enable_scenario();
        host.set_enable(1'b0);
        step(2);
        check("mirror_off", enable_mirror_output, 1'b0);
        check("pin_off", fault_pin, 1'b1);
        host.kick();
        hold_quiet("enable_low", lim + 20);
        host.set_enable(1'b1);
        step(2);
        check("mirror_on", enable_mirror_output, 1'b1);
        expect_fault("refault", 1500 + lim - 8, 1500 + lim + 8);
    endtask
    initial begin
        rst_n = 1'b0;
        run_mode(1'b0, 11'h005, SLOPE * 5 + OFFS);
        run_mode(1'b1, 11'h005, 50);
        run_mode(1'b0, 11'h000, 200);
        select_scenario();
        enable_scenario();
        tally_and_finish();
    end
endmodule // programmable_watchdog_timer_tb
`default_nettype wire
